/* File: shared/ptec_regs.svh */
// Purpose: Constants for the pattern trigger and event control block.
// Assumes: Included by its bare name from the design files.
// Notes: Source and event codes are shared by all select ports.
//
// Notes on behaviour
// R1 - Start, pause, script triggers arrive asynchronously; reaction takes some cycles.
// R2 - Ready, data-active and marker events leave aligned with generated data; ready here comes from the state and skips the position delay.
// R3 - Start fires on chosen edge of one function line or trigger bus line.
// R4 - A software start acts exactly like a hardware start.
// R5 - Start can be driven onto function lines or trigger bus lines 0-6.
// R6 - Pause is a level; generation halts while it is high; any source.
// R7 - Pause can be driven onto function lines or trigger bus lines 0-6.
// R8 - Four script triggers, each edge or level, hardware line or software.
// R9 - Each script trigger can be driven onto function or bus lines 0-6.
// R10 - Ready-for-start can be driven onto function or bus lines 0-6.
// R11 - Data-active goes to function lines only, never to the bus.
// R12 - Each of four markers can go to function or bus lines 0-6.
// R13 - Fetched words pass through position delay before the channel drivers.
// R14 - A driver floats when idle state or software asks for tristate.
// R15 - Open-collector channels float on a 1 and drive only a 0.
// R16 - Each channel drives and acquires at the same time.
// R17 - Two comparator outputs merge into one bit by the chosen method.
// R18 - Acquisition stores words only after start and while not paused.
// R19 - Data and clock shifting work only above 25 MHz.
// R20 - Idle, wait for start with ready asserted, run, then done.
// R21 - Hysteresis: mid-band repeats last level; below low 0, above high 1.
// R22 - Validity: mid-band gives 1, above high or below low gives 0.
// R23 - Every hardware trigger line passes two flip-flops before detection.
// R24 - Level triggers act every cycle; edge triggers once per transition.
`ifndef PTEC_REGS_SVH
`define PTEC_REGS_SVH

// Trigger sources: 0-3 function lines, 4-11 trigger bus lines, else none
`define PTEC_SRC_COUNT 4'd12
`define PTEC_SRC_NONE 4'hf

// Event codes for the output line selects
`define PTEC_EV_NONE 4'h0
`define PTEC_EV_START 4'h1
`define PTEC_EV_PAUSE 4'h2
`define PTEC_EV_SCRIPT0 4'h3
`define PTEC_EV_READY 4'h7
`define PTEC_EV_ACTIVE 4'h8
`define PTEC_EV_MARKER0 4'h9

// Shifting threshold in kHz
`define PTEC_SHIFT_MIN_KHZ 18'd25000

// Reset values
`define PTEC_ZERO20 20'h00000
`define PTEC_ONES20 20'hfffff
`define PTEC_ZERO2 2'h0

`endif

/* File: shared/ptec_pkg.sv */
// Purpose: Types for the pattern trigger and event control block.
// Assumes: Compiled before the design modules.
// Notes: Numeric constants live in ptec_regs.svh.
package ptec_pkg;

  typedef enum logic [1:0] {
    PTEC_IDLE,
    PTEC_WAIT_START,
    PTEC_RUN,
    PTEC_DONE
  } ptec_state_type;

  typedef enum logic {
    PTEC_HYSTERESIS,
    PTEC_VALIDITY
  } ptec_interp_type;

endpackage : ptec_pkg

/* File: src/ptec_buf.sv */
// Purpose: Two-entry buffer in the generation data path.
// Assumes: Source and sink share core_clk_in.
// Notes: in_ready_out is registered so a stall never drops a word.
`timescale 1ns/1ps
`default_nettype none
module ptec_buf (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // Fill side
  input wire logic [24:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  // Drain side
  output logic [24:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  logic [24:0] mem_reg [2];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic [1:0] count_next;
  logic ready_reg;
  wire push = in_valid_in && ready_reg;
  wire pop = out_ready_in && (count_reg != 2'h0);

  assign count_next = (push && !pop) ? count_reg + 2'h1 :
                      (!push && pop) ? count_reg - 2'h1 : count_reg;
  assign in_ready_out = ready_reg;
  assign out_valid_out = (count_reg != 2'h0);
  assign out_data_out = mem_reg[rd_ptr_reg];

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
      ready_reg <= 1'b0;
    end else if (clk_en_in) begin
      if (push) begin
        wr_ptr_reg <= !wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= !rd_ptr_reg;
      end
      count_reg <= count_next;
      ready_reg <= (count_next != 2'h2);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (clk_en_in && push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end
endmodule : ptec_buf
`default_nettype wire

/* File: src/ptec_top.sv */
// Purpose: Trigger, event, channel and acquisition control around the
//          pattern generation engine.
// Assumes: Trigger lines and comparators are asynchronous; all other
//          inputs come from logic on core_clk_in.
// Notes: Output lines are two-way pins; oe_n low means this block drives.
`timescale 1ns/1ps
`default_nettype none
`include "ptec_regs.svh"
module ptec_top (
  // Clock, reset, enable
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // Trigger pins
  input wire logic [3:0] front_function_line_in,
  input wire logic [7:0] board_sync_trigger_bus_in,
  // Trigger configuration and software triggers
  input wire logic [3:0] start_src_sel_in,
  input wire logic start_falling_in,
  input wire logic sw_start_in,
  input wire logic [3:0] pause_src_sel_in,
  input wire logic sw_pause_in,
  input wire logic [15:0] script_src_sel_in,
  input wire logic [3:0] script_level_mode_in,
  input wire logic [3:0] sw_script_in,
  // Event routing and line outputs
  input wire logic [15:0] func_route_sel_in,
  input wire logic [27:0] bus_route_sel_in,
  output logic [3:0] front_function_line_out,
  output logic [3:0] front_function_line_oe_n_out,
  output logic [6:0] board_sync_trigger_bus_out,
  output logic [6:0] board_sync_trigger_bus_oe_n_out,
  // Engine control
  input wire logic initiate_in,
  input wire logic abort_in,
  output var ptec_pkg::ptec_state_type engine_state_out,
  output logic [3:0] script_trig_out,
  // Generation stream from memory fetch
  input wire logic [19:0] gen_data_in,
  input wire logic [3:0] gen_marker_in,
  input wire logic gen_last_in,
  input wire logic gen_valid_in,
  output logic gen_ready_out,
  // Channel drivers
  input wire logic [19:0] open_collector_in,
  input wire logic [19:0] idle_tristate_in,
  input wire logic [19:0] sw_tristate_in,
  output logic [19:0] pattern_channel_out,
  output logic [19:0] pattern_channel_oe_n_out,
  // Acquisition
  input wire logic [19:0] comp_high_in,
  input wire logic [19:0] comp_low_in,
  input wire ptec_pkg::ptec_interp_type interp_sel_in,
  input wire logic acq_enable_in,
  output logic [19:0] acq_data_out,
  output logic acq_write_out,
  // Timing position
  input wire logic [17:0] sample_freq_khz_in,
  input wire logic [1:0] gen_delay_in,
  input wire logic [1:0] acq_delay_in,
  input wire logic [1:0] clk_export_delay_in,
  output logic [1:0] clk_export_delay_out,
  output logic shift_allowed_out
);
  import ptec_pkg::*;

  // ----
  // Input synchronisers
  // ----
  logic [11:0] trig_s1_reg;
  logic [11:0] trig_s2_reg;
  logic [11:0] trig_prev_reg;
  logic [19:0] hi_s1_reg;
  logic [19:0] hi_s2_reg;
  logic [19:0] lo_s1_reg;
  logic [19:0] lo_s2_reg;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      trig_s1_reg <= 12'h000;
      trig_s2_reg <= 12'h000;
      trig_prev_reg <= 12'h000;
      hi_s1_reg <= `PTEC_ZERO20;
      hi_s2_reg <= `PTEC_ZERO20;
      lo_s1_reg <= `PTEC_ZERO20;
      lo_s2_reg <= `PTEC_ZERO20;
    end else if (clk_en_in) begin
      trig_s1_reg <= {board_sync_trigger_bus_in, front_function_line_in}; // [R1]
      trig_s2_reg <= trig_s1_reg; // [R23]
      trig_prev_reg <= trig_s2_reg;
      hi_s1_reg <= comp_high_in;
      hi_s2_reg <= hi_s1_reg;
      lo_s1_reg <= comp_low_in;
      lo_s2_reg <= lo_s1_reg;
    end
  end

  // ----
  // Trigger detection
  // ----
  function automatic logic pick(input logic [11:0] v, input logic [3:0] s);
    pick = (s < `PTEC_SRC_COUNT) ? v[s] : 1'b0;
  endfunction : pick

  wire start_now = pick(trig_s2_reg, start_src_sel_in);
  wire start_old = pick(trig_prev_reg, start_src_sel_in);
  wire start_edge = start_falling_in ? (!start_now && start_old) :
                                       (start_now && !start_old); // [R3]
  wire start_fire = start_edge || sw_start_in; // [R4]
  wire pause_level = pick(trig_s2_reg, pause_src_sel_in) || sw_pause_in; // [R6]
  logic [3:0] script_hit;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_script
      wire [3:0] sel = script_src_sel_in[gi*4 +: 4];
      wire now = pick(trig_s2_reg, sel);
      wire old = pick(trig_prev_reg, sel);
      assign script_hit[gi] = (script_level_mode_in[gi] ? now : (now && !old))
                              || sw_script_in[gi]; // [R8] [R24]
    end
  endgenerate

  // ----
  // Engine state
  // ----
  ptec_state_type state_reg;
  ptec_state_type state_next;
  logic [24:0] buf_data;
  logic buf_valid;
  wire drain = (state_reg == PTEC_RUN) && !pause_level; // [R6]
  wire take = drain && buf_valid;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PTEC_IDLE: begin
        if (initiate_in) state_next = PTEC_WAIT_START; // [R20]
      end
      PTEC_WAIT_START: begin
        if (start_fire) state_next = PTEC_RUN; // [R20]
      end
      PTEC_RUN: begin
        if (take && buf_data[24]) state_next = PTEC_DONE; // [R20]
      end
      PTEC_DONE: begin
        if (initiate_in) state_next = PTEC_WAIT_START;
      end
    endcase
    if (abort_in) state_next = PTEC_IDLE;
  end

  ptec_buf u_buf (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .in_data_in({gen_last_in, gen_marker_in, gen_data_in}),
    .in_valid_in(gen_valid_in),
    .in_ready_out(gen_ready_out),
    .out_data_out(buf_data),
    .out_valid_out(buf_valid),
    .out_ready_in(drain)
  );

  // ----
  // Generation stage and position delay
  // ----
  logic [19:0] st_data_reg;
  logic [3:0] st_marker_reg;
  logic st_active_reg;
  logic [44:0] gen_pipe_reg [4];
  logic [44:0] gen_sel_reg;
  wire shift_ok = sample_freq_khz_in > `PTEC_SHIFT_MIN_KHZ; // [R19]
  wire [1:0] gen_dly = shift_ok ? gen_delay_in : `PTEC_ZERO2;
  wire [1:0] acq_dly = shift_ok ? acq_delay_in : `PTEC_ZERO2;
  wire idle_now = (state_reg != PTEC_RUN);
  wire [19:0] tri_now = sw_tristate_in
                        | (idle_now ? idle_tristate_in : `PTEC_ZERO20) // [R14]
                        | (open_collector_in & st_data_reg); // [R15]

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_reg <= PTEC_IDLE;
      st_data_reg <= `PTEC_ZERO20;
      st_marker_reg <= 4'h0;
      st_active_reg <= 1'b0;
    end else if (clk_en_in) begin
      state_reg <= state_next;
      st_active_reg <= take;
      st_marker_reg <= take ? buf_data[23:20] : 4'h0;
      if (take) begin
        st_data_reg <= buf_data[19:0]; // [R13]
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      gen_pipe_reg[0] <= {5'h00, `PTEC_ONES20, `PTEC_ZERO20};
    end else if (clk_en_in) begin
      gen_pipe_reg[0] <= {st_active_reg, st_marker_reg, tri_now, st_data_reg};
    end
  end

  generate
    for (gi = 1; gi < 4; gi++) begin : g_gpipe
      always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
          gen_pipe_reg[gi] <= {5'h00, `PTEC_ONES20, `PTEC_ZERO20};
        end else if (clk_en_in) begin
          gen_pipe_reg[gi] <= gen_pipe_reg[gi-1]; // [R13]
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      gen_sel_reg <= {5'h00, `PTEC_ONES20, `PTEC_ZERO20};
      clk_export_delay_out <= `PTEC_ZERO2;
      shift_allowed_out <= 1'b0;
    end else if (clk_en_in) begin
      gen_sel_reg <= gen_pipe_reg[gen_dly]; // [R19]
      clk_export_delay_out <= shift_ok ? clk_export_delay_in
                                       : `PTEC_ZERO2; // [R19]
      shift_allowed_out <= shift_ok;
    end
  end

  assign pattern_channel_out = gen_sel_reg[19:0];
  assign pattern_channel_oe_n_out = gen_sel_reg[39:20];

  // ----
  // Acquisition
  // ----
  logic [19:0] hyst_reg;
  logic [19:0] hyst_next;
  logic [19:0] merged;
  logic acq_run_reg;
  logic [20:0] acq_pipe_reg [4];
  logic [20:0] acq_sel_reg;
  wire acq_store = acq_run_reg && acq_enable_in && !pause_level; // [R18]

  generate
    for (gi = 0; gi < 20; gi++) begin : g_interp
      assign hyst_next[gi] = hi_s2_reg[gi] ? 1'b1 :
                             !lo_s2_reg[gi] ? 1'b0 : hyst_reg[gi]; // [R21]
      assign merged[gi] = (interp_sel_in == PTEC_VALIDITY) ?
                          (lo_s2_reg[gi] && !hi_s2_reg[gi]) : // [R22]
                          hyst_next[gi]; // [R17]
    end
  endgenerate

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      hyst_reg <= `PTEC_ZERO20;
      acq_run_reg <= 1'b0;
      acq_pipe_reg[0] <= 21'h000000;
    end else if (clk_en_in) begin
      hyst_reg <= hyst_next; // [R16]
      if (!acq_enable_in) begin
        acq_run_reg <= 1'b0;
      end else if (start_fire) begin
        acq_run_reg <= 1'b1; // [R18]
      end
      acq_pipe_reg[0] <= {acq_store, merged};
    end
  end

  generate
    for (gi = 1; gi < 4; gi++) begin : g_apipe
      always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
          acq_pipe_reg[gi] <= 21'h000000;
        end else if (clk_en_in) begin
          acq_pipe_reg[gi] <= acq_pipe_reg[gi-1];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      acq_sel_reg <= 21'h000000;
    end else if (clk_en_in) begin
      acq_sel_reg <= acq_pipe_reg[acq_dly]; // [R19]
    end
  end

  assign acq_data_out = acq_sel_reg[19:0];
  assign acq_write_out = acq_sel_reg[20];

  // ----
  // Events and line routing
  // ----
  logic start_ev_reg;
  logic pause_ev_reg;
  logic ready_ev_reg;
  logic [15:0] events;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      start_ev_reg <= 1'b0;
      pause_ev_reg <= 1'b0;
      ready_ev_reg <= 1'b0;
      script_trig_out <= 4'h0;
    end else if (clk_en_in) begin
      start_ev_reg <= start_fire && (state_reg == PTEC_WAIT_START);
      pause_ev_reg <= pause_level;
      ready_ev_reg <= (state_next == PTEC_WAIT_START); // [R20]
      script_trig_out <= (state_reg == PTEC_RUN) ? script_hit : 4'h0;
    end
  end

  // Active and markers come from the delayed word so they stay aligned
  assign events = {3'h0, gen_sel_reg[43:40], gen_sel_reg[44], ready_ev_reg,
                   script_trig_out, pause_ev_reg, start_ev_reg,
                   1'b0}; // [R2]
  assign engine_state_out = state_reg;

  generate
    for (gi = 0; gi < 4; gi++) begin : g_func
      wire [3:0] sel = func_route_sel_in[gi*4 +: 4];
      always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
          front_function_line_out[gi] <= 1'b0;
          front_function_line_oe_n_out[gi] <= 1'b1;
        end else if (clk_en_in) begin
          front_function_line_out[gi] <= events[sel]; // [R5] [R7] [R9]
          front_function_line_oe_n_out[gi] <= (sel == `PTEC_EV_NONE);
        end
      end
    end
    for (gi = 0; gi < 7; gi++) begin : g_bus
      wire [3:0] sel = bus_route_sel_in[gi*4 +: 4];
      wire off = (sel == `PTEC_EV_NONE) || (sel == `PTEC_EV_ACTIVE); // [R11]
      always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
          board_sync_trigger_bus_out[gi] <= 1'b0;
          board_sync_trigger_bus_oe_n_out[gi] <= 1'b1;
        end else if (clk_en_in) begin
          board_sync_trigger_bus_out[gi] <= off ? 1'b0 : events[sel]; // [R10] [R12]
          board_sync_trigger_bus_oe_n_out[gi] <= off;
        end
      end
    end
  endgenerate
endmodule : ptec_top
`default_nettype wire

/* File: tb/ptec_monitor.sv */
// Purpose: Port checks for ptec_top.
// Assumes: One clock, synchronous reset.
// Notes: Bound to every ptec_top.
`timescale 1ns/1ps
`default_nettype none
`include "ptec_regs.svh"
module ptec_monitor (
  // Clock and control
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic initiate_in,
  input wire logic abort_in,
  input wire logic sw_start_in,
  // Triggers and routing
  input wire logic [3:0] front_function_line_in,
  input wire logic [3:0] start_src_sel_in,
  input wire logic start_falling_in,
  input wire logic [27:0] bus_route_sel_in,
  input wire logic [6:0] board_sync_trigger_bus_oe_n_out,
  // Engine and channels
  input wire ptec_pkg::ptec_state_type engine_state_out,
  input wire logic [3:0] script_trig_out,
  input wire logic gen_ready_out,
  input wire logic [19:0] open_collector_in,
  input wire logic [19:0] sw_tristate_in,
  input wire logic [19:0] pattern_channel_out,
  input wire logic [19:0] pattern_channel_oe_n_out,
  input wire logic acq_enable_in,
  input wire logic acq_write_out,
  // Timing
  input wire logic [17:0] sample_freq_khz_in,
  input wire logic [1:0] clk_export_delay_in,
  input wire logic [1:0] clk_export_delay_out,
  input wire logic shift_allowed_out
);
  import ptec_pkg::*;
  // ----
  // Checks
  // ----
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);
  sequence line_rise_s;
    (!front_function_line_in[0]) [*3] ##1 front_function_line_in[0];
  endsequence
  sequence armed_s;
    engine_state_out == PTEC_WAIT_START && start_src_sel_in == 4'h0 &&
      !start_falling_in && clk_en_in && !abort_in;
  endsequence
  chk_reset_idle: assert property (disable iff (1'b0)
    rst_in && clk_en_in |=> engine_state_out == PTEC_IDLE &&
    !gen_ready_out) else $error("reset left engine busy");
  chk_init_wait: assert property (
    engine_state_out == PTEC_IDLE && initiate_in && clk_en_in && !abort_in
    |=> engine_state_out == PTEC_WAIT_START) else $error("no wait");
  chk_abort_idle: assert property (
    abort_in && clk_en_in |=> engine_state_out == PTEC_IDLE)
    else $error("abort ignored");
  chk_sw_start: assert property (
    engine_state_out == PTEC_WAIT_START && sw_start_in && clk_en_in &&
    !abort_in |=> engine_state_out == PTEC_RUN) else $error("no sw start");
  chk_hw_start: assert property (line_rise_s ##0 armed_s |->
    ##[1:4] engine_state_out inside {PTEC_RUN, PTEC_DONE})
    else $error("no hw start");
  chk_script_quiet: assert property (
    engine_state_out != PTEC_RUN && $past(engine_state_out) != PTEC_RUN
    |-> script_trig_out == 4'h0) else $error("script outside run");
  chk_shift_gate: assert property (
    sample_freq_khz_in > `PTEC_SHIFT_MIN_KHZ && clk_en_in |=>
    shift_allowed_out && clk_export_delay_out == $past(clk_export_delay_in))
    else $error("shift not applied");
  chk_oc_float: assert property (
    open_collector_in[0] [*8] ##0 pattern_channel_out[0]
    |-> pattern_channel_oe_n_out[0]) else $error("oc one driven");
  chk_sw_float: assert property (
    sw_tristate_in[0] [*8] |-> pattern_channel_oe_n_out[0])
    else $error("tristate ignored");
  chk_bus_no_active: assert property (
    bus_route_sel_in[3:0] == `PTEC_EV_ACTIVE && clk_en_in
    |=> board_sync_trigger_bus_oe_n_out[0]) else $error("active on bus");
  chk_acq_gate: assert property (
    (!acq_enable_in) [*8] |-> !acq_write_out) else $error("write disabled");
endmodule : ptec_monitor
bind ptec_top ptec_monitor u_mon (.*);
`default_nettype wire

/* File: tb/ptec_far_model.sv */
// Purpose: Device under test and chassis lines facing ptec_top.
// Assumes: Released lines show the level the bench picks.
// Notes: Band code {high, low}: 00 below, 01 mid, 11 above.
`timescale 1ns/1ps
`default_nettype none
module ptec_far_model (
  // Far side levels
  input wire logic [3:0] ext_func_in,
  input wire logic [7:0] ext_bus_in,
  input wire logic [1:0] ext_band_in,
  // Block pins
  input wire logic [3:0] func_out_in,
  input wire logic [3:0] func_oe_n_in,
  input wire logic [6:0] bus_out_in,
  input wire logic [6:0] bus_oe_n_in,
  input wire logic [19:0] pat_out_in,
  input wire logic [19:0] pat_oe_n_in,
  // Resolved wires
  output logic [3:0] func_wire_out,
  output logic [7:0] bus_wire_out,
  output logic [19:0] comp_high_out,
  output logic [19:0] comp_low_out
);
  assign func_wire_out = (func_oe_n_in & ext_func_in) |
    (~func_oe_n_in & func_out_in);
  assign bus_wire_out = {ext_bus_in[7], (bus_oe_n_in & ext_bus_in[6:0]) |
    (~bus_oe_n_in & bus_out_in)};
  // Driven channels loop back into both comparators
  assign comp_high_out = (pat_oe_n_in & {20{ext_band_in[1]}}) |
    (~pat_oe_n_in & pat_out_in);
  assign comp_low_out = (pat_oe_n_in & {20{ext_band_in[0]}}) |
    (~pat_oe_n_in & pat_out_in);
endmodule : ptec_far_model
`default_nettype wire

/* File: tb/test_ptec_top.sv */
// Purpose: Self-checking bench for ptec_top.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Each scenario judges its own results.
`timescale 1ns/1ps
`default_nettype none
module test_ptec_top;
  import ptec_pkg::*;
  localparam logic [13:0] band_seq = 14'h0d47;
  localparam logic [6:0] mode_seq = 7'h70;
  localparam logic [6:0] bit_seq = 7'h13;
  logic core_clk_in, rst_in, clk_en_in, start_falling_in, sw_start_in;
  logic sw_pause_in, initiate_in, abort_in, gen_last_in, gen_valid_in;
  logic gen_ready_out, acq_enable_in, acq_write_out, shift_allowed_out;
  logic [3:0] front_function_line_in, start_src_sel_in, pause_src_sel_in;
  logic [3:0] script_level_mode_in, sw_script_in, script_trig_out;
  logic [3:0] front_function_line_out, front_function_line_oe_n_out;
  logic [3:0] gen_marker_in, ext_func;
  logic [7:0] board_sync_trigger_bus_in, ext_bus;
  logic [6:0] board_sync_trigger_bus_out, board_sync_trigger_bus_oe_n_out;
  logic [15:0] script_src_sel_in, func_route_sel_in;
  logic [27:0] bus_route_sel_in;
  logic [19:0] gen_data_in, open_collector_in, idle_tristate_in;
  logic [19:0] sw_tristate_in, pattern_channel_out, pattern_channel_oe_n_out;
  logic [19:0] comp_high_in, comp_low_in, acq_data_out;
  logic [17:0] sample_freq_khz_in;
  logic [1:0] gen_delay_in, acq_delay_in, clk_export_delay_in;
  logic [1:0] clk_export_delay_out, ext_band;
  ptec_state_type engine_state_out;
  ptec_interp_type interp_sel_in;
  int num_errors, check_count;
  ptec_top DUT (.*);
  ptec_far_model u_far (.ext_func_in(ext_func), .ext_bus_in(ext_bus),
    .ext_band_in(ext_band), .func_out_in(front_function_line_out),
    .func_oe_n_in(front_function_line_oe_n_out),
    .bus_out_in(board_sync_trigger_bus_out),
    .bus_oe_n_in(board_sync_trigger_bus_oe_n_out),
    .pat_out_in(pattern_channel_out), .pat_oe_n_in(pattern_channel_oe_n_out),
    .func_wire_out(front_function_line_in),
    .bus_wire_out(board_sync_trigger_bus_in),
    .comp_high_out(comp_high_in), .comp_low_out(comp_low_in));
  // ----
  // Helpers
  // ----
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  task tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : tick
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : pulse
  task push(input logic [23:0] d, input logic last);
    {gen_marker_in, gen_data_in} = d;
    gen_last_in = last;
    gen_valid_in = 1'b1;
    for (int i = 0; i < 8 && gen_ready_out !== 1'b1; i++) tick(1);
    tick(1);
  endtask : push
  task wait_word(input logic [19:0] w);
    for (int i = 0; i < 12 && pattern_channel_out !== w; i++) tick(1);
  endtask : wait_word
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  // ----
  // Scenarios
  // ----
  task t_reset;
    chk("state", PTEC_IDLE, engine_state_out);
    chk("func oe_n", 4'hf, front_function_line_oe_n_out);
    chk("gen ready", 1'b0, gen_ready_out);
    tick(1);
    chk("gen ready", 1'b1, gen_ready_out);
    chk("func oe_n", 4'h9, front_function_line_oe_n_out);
    chk("bus oe_n", 7'h69, board_sync_trigger_bus_oe_n_out);
    $display("reset test done");
  endtask : t_reset
  task t_shift;
    clk_export_delay_in = 2'h2;
    sample_freq_khz_in = 18'h061a8;
    tick(2);
    chk("shift", 1'b0, shift_allowed_out);
    chk("clk delay", 2'h0, clk_export_delay_out);
    sample_freq_khz_in = 18'h061a9;
    tick(2);
    chk("shift", 1'b1, shift_allowed_out);
    chk("clk delay", 2'h2, clk_export_delay_out);
    $display("shift test done");
  endtask : t_shift
  task t_sw_start;
    pulse(initiate_in);
    tick(2);
    chk("state", PTEC_WAIT_START, engine_state_out);
    chk("ready line", 1'b1, board_sync_trigger_bus_out[2]);
    chk("idle oe_n", 2'h1, pattern_channel_oe_n_out[3:2]);
    pulse(sw_start_in);
    chk("state", PTEC_RUN, engine_state_out);
    tick(1);
    chk("start line", 1'b1, front_function_line_out[2]);
    chk("ready line", 1'b0, board_sync_trigger_bus_out[2]);
    sw_script_in = 4'h4;
    tick(3);
    chk("script", 4'h4, script_trig_out);
    sw_script_in = 4'h0;
    pulse(abort_in);
    chk("state", PTEC_IDLE, engine_state_out);
    $display("software start test done");
  endtask : t_sw_start
  task t_stream;
    pulse(initiate_in);
    ext_func[3] = 1'b1;
    push(24'h100001, 1'b0);
    push(24'h000003, 1'b1);
    gen_valid_in = 1'b0;
    tick(1);
    chk("gen ready", 1'b0, gen_ready_out);
    pulse(sw_start_in);
    tick(8);
    chk("paused data", 20'h0, pattern_channel_out);
    chk("pause line", 1'b1, board_sync_trigger_bus_out[1]);
    ext_func[3] = 1'b0;
    wait_word(20'h00001);
    chk("data", 20'h00001, pattern_channel_out);
    chk("data oe_n", 2'h1, pattern_channel_oe_n_out[1:0]);
    wait_word(20'h00003);
    chk("data oe_n", 2'h1, pattern_channel_oe_n_out[1:0]);
    chk("active line", 1'b1, front_function_line_out[1]);
    chk("marker line", 1'b1, board_sync_trigger_bus_out[4]);
    tick(3);
    chk("state", PTEC_DONE, engine_state_out);
    $display("stream test done");
  endtask : t_stream
  task t_hw_start;
    for (int k = 0; k < 2; k++) begin
      start_src_sel_in = k[0] ? 4'h7 : 4'h0;
      start_falling_in = k[0];
      pulse(initiate_in);
      tick(3);
      ext_func[0] = !k[0];
      ext_bus[3] = !k[0];
      tick(1);
      chk("state", PTEC_WAIT_START, engine_state_out);
      tick(2);
      chk("state", PTEC_RUN, engine_state_out);
      pulse(abort_in);
    end
    $display("hardware start test done");
  endtask : t_hw_start
  task t_acquire;
    acq_enable_in = 1'b1;
    pulse(initiate_in);
    pulse(sw_start_in);
    sw_tristate_in = 20'hfffff;
    for (int k = 0; k < 7; k++) begin
      ext_band = band_seq[2*k +: 2];
      interp_sel_in = ptec_interp_type'(mode_seq[k]);
      tick(8);
      chk("acq write", 1'b1, acq_write_out);
      chk("acq bit", bit_seq[k], acq_data_out[0]);
    end
    sw_pause_in = 1'b1;
    tick(8);
    chk("acq write", 1'b0, acq_write_out);
    sw_pause_in = 1'b0;
    acq_enable_in = 1'b0;
    $display("acquisition test done");
  endtask : t_acquire
  // Whole run is under two hundred cycles
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end
  initial begin
    rst_in = 1'b1;
    clk_en_in = 1'b1;
    {start_falling_in, sw_start_in, sw_pause_in, initiate_in, abort_in} = '0;
    {gen_last_in, gen_valid_in, acq_enable_in} = '0;
    {sw_script_in, gen_marker_in, ext_func, ext_band} = '0;
    {gen_data_in, sw_tristate_in, gen_delay_in, acq_delay_in} = '0;
    {clk_export_delay_in, sample_freq_khz_in} = '0;
    start_src_sel_in = 4'hf;
    pause_src_sel_in = 4'h3;
    script_src_sel_in = 16'hffff;
    script_level_mode_in = 4'hf;
    func_route_sel_in = 16'h0180;
    bus_route_sel_in = 28'h0090728;
    open_collector_in = 20'h00001;
    idle_tristate_in = 20'h00004;
    ext_bus = 8'hff;
    interp_sel_in = PTEC_HYSTERESIS;
    tick(6);
    rst_in = 1'b0;
    t_reset();
    t_shift();
    t_sw_start();
    t_stream();
    t_hw_start();
    t_acquire();
    print_verdict();
  end
endmodule : test_ptec_top
`default_nettype wire
